/* logic/sld_driver.sv */
// Eight-stage serial-in shift register with load latches and gated sink outputs
`timescale 1ns/100ps
module sld_driver import sld_pkg::*; #(
  parameter int unsigned N_STAGES = STAGES,
  parameter int unsigned F_DEPTH  = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  // Link pins from the controller
  input  wire logic                shift_clk,
  input  wire logic                serial_in,
  input  wire logic                load,
  input  wire logic                out_disable,
  // Local control
  input  wire logic                shift_hold,
  // Link status
  output logic                     in_ready,
  output logic                     bit_lost,
  output logic                     load_gap_err,
  // Cascade and sink outputs
  output logic                     serial_out,
  output logic [N_STAGES-1:0]      out_on
);

  initial begin
    if (N_STAGES != STAGES)
      $error("sld_driver: stage count is fixed at eight");
    if (F_DEPTH < 2)
      $error("sld_driver: FIFO depth too small");
  end

  // Pin synchronisers: index 0 clock, 1 data, 2 load, 3 disable
  logic [3:0] sync1_reg;
  logic [3:0] sync1_next;
  logic [3:0] sync2_reg;
  logic [3:0] sync2_next;
  logic       clk_prev_reg;
  logic       clk_prev_next;
  logic       load_prev_reg;
  logic       load_prev_next;

  logic clk_s;
  logic data_s;
  logic load_s;
  logic dis_s;
  logic clk_rise;
  logic load_rise;

  always_comb begin
    sync1_next     = {out_disable, load, serial_in, shift_clk};
    sync2_next     = sync1_reg;
    clk_prev_next  = sync2_reg[0];
    load_prev_next = sync2_reg[2];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_reg     <= {SYNC_RESET, SYNC_RESET};
      sync2_reg     <= {SYNC_RESET, SYNC_RESET};
      clk_prev_reg  <= 1'b0;
      load_prev_reg <= 1'b0;
    end else begin
      sync1_reg     <= sync1_next;
      sync2_reg     <= sync2_next;
      clk_prev_reg  <= clk_prev_next;
      load_prev_reg <= load_prev_next;
    end
  end

  assign clk_s     = sync2_reg[0];
  assign data_s    = sync2_reg[1];
  assign load_s    = sync2_reg[2];
  assign dis_s     = sync2_reg[3];
  // Data and clock share the same synchroniser depth, so data set up
  // before the clock edge is still ahead of it here
  assign clk_rise  = clk_s & ~clk_prev_reg;
  assign load_rise = load_s & ~load_prev_reg;

  // Captured bits queue here so a local hold drops no link edges until F_DEPTH bits are waiting
  sld_stream_if #(.WIDTH(1)) cap_if ();
  sld_stream_if #(.WIDTH(1)) sh_if ();

  assign cap_if.valid = clk_rise;
  assign cap_if.data  = data_s;
  assign sh_if.ready  = ~shift_hold;
  assign in_ready     = cap_if.ready;

  sld_fifo #(
    .WIDTH (1),
    .DEPTH (F_DEPTH)
  ) u_fifo (
    .clk   (clk),
    .rst_n (rst_n),
    .fill  (cap_if),
    .drain (sh_if)
  );

  logic shift_en;
  assign shift_en = sh_if.valid & sh_if.ready;

  // Shift register and latches carry no reset; known masks track which
  // stages hold shifted-in data so outputs never show unknown values
  logic [N_STAGES-1:0] shreg_reg;
  logic [N_STAGES-1:0] shreg_next;
  logic [N_STAGES-1:0] sh_known_reg;
  logic [N_STAGES-1:0] sh_known_next;
  logic [N_STAGES-1:0] latch_reg;
  logic [N_STAGES-1:0] latch_next;
  logic [N_STAGES-1:0] lat_known_reg;
  logic [N_STAGES-1:0] lat_known_next;
  logic                latch_open;

  // Latches only open once every queued bit has reached the register
  assign latch_open = load_s & ~sh_if.valid;

  always_comb begin
    shreg_next     = shreg_reg;
    sh_known_next  = sh_known_reg;
    latch_next     = latch_reg;
    lat_known_next = lat_known_reg;
    if (shift_en) begin
      shreg_next    = {shreg_reg[N_STAGES-2:0], sh_if.data};
      sh_known_next = {sh_known_reg[N_STAGES-2:0], 1'b1};
    end
    if (latch_open) begin
      latch_next     = shreg_reg;
      lat_known_next = sh_known_reg;
    end
    // Disable is not looked at here, so it cannot disturb stored data
  end

  always_ff @(posedge clk) begin
    shreg_reg <= shreg_next;
    latch_reg <= latch_next;
    if (!rst_n) begin
      sh_known_reg  <= '0;
      lat_known_reg <= '0;
    end else begin
      sh_known_reg  <= sh_known_next;
      lat_known_reg <= lat_known_next;
    end
  end

  // Spacing between shift edge and load; the gap is the controller's
  // duty, flagged here so a fast controller can be caught
  logic [3:0] gap_cnt_reg;
  logic [3:0] gap_cnt_next;
  logic       gap_err_reg;
  logic       gap_err_next;
  logic       lost_reg;
  logic       lost_next;
  localparam logic [3:0] GAP_FULL = 4'(LOAD_GAP_CYC);

  always_comb begin
    gap_cnt_next = gap_cnt_reg;
    gap_err_next = gap_err_reg;
    lost_next    = lost_reg;
    if (clk_rise) begin
      gap_cnt_next = GAP_CNT_RESET;
    end else if (gap_cnt_reg < GAP_FULL) begin
      gap_cnt_next = gap_cnt_reg + 4'h1;
    end
    // Count reads one less than the cycles since the edge; exactly the gap is legal
    if (load_rise && (clk_rise || (gap_cnt_reg + 4'h1) < GAP_FULL)) begin
      gap_err_next = 1'b1;
    end
    if (clk_rise && !cap_if.ready) begin
      lost_next = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gap_cnt_reg <= GAP_FULL;
      gap_err_reg <= 1'b0;
      lost_reg    <= 1'b0;
    end else begin
      gap_cnt_reg <= gap_cnt_next;
      gap_err_reg <= gap_err_next;
      lost_reg    <= lost_next;
    end
  end

  assign load_gap_err = gap_err_reg;
  assign bit_lost     = lost_reg;

  // Output stage, registered
  logic [N_STAGES-1:0] out_on_reg;
  logic [N_STAGES-1:0] out_on_next;
  logic                ser_out_reg;
  logic                ser_out_next;

  always_comb begin
    ser_out_next = shreg_next[N_STAGES-1] & sh_known_next[N_STAGES-1];
    if (dis_s) begin
      out_on_next = '0;
    end else begin
      out_on_next = latch_reg & lat_known_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_on_reg  <= '0;
      ser_out_reg <= 1'b0;
    end else begin
      out_on_reg  <= out_on_next;
      ser_out_reg <= ser_out_next;
    end
  end

  assign out_on     = out_on_reg;
  assign serial_out = ser_out_reg;

endmodule // sld_driver

/* pkg/sld_pkg.sv */
// Constants shared by the serial latched driver and its FIFO
package sld_pkg;
  localparam int unsigned STAGES        = 8;
  localparam int unsigned FIFO_DEPTH    = 16;
  localparam int unsigned FIFO_WIDTH    = 1;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned LOAD_GAP_NS   = 300;
  // Least time rounds up to whole cycles, never below one
  localparam int unsigned LOAD_GAP_RAW  = (LOAD_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LOAD_GAP_CYC  = (LOAD_GAP_RAW < 1) ? 1 : LOAD_GAP_RAW;
  localparam logic [3:0]  GAP_CNT_RESET = 4'h0;
  localparam logic [1:0]  SYNC_RESET    = 2'h0;
endpackage

/* pkg/sld_stream_if.sv */
// Valid/ready stream carrier between driver and FIFO
`timescale 1ns/100ps
interface sld_stream_if #(parameter int unsigned WIDTH = 1);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* logic/sld_fifo.sv */
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module sld_fifo import sld_pkg::*; #(
  parameter int unsigned WIDTH = FIFO_WIDTH,
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Streams
  sld_stream_if.snk fill,
  sld_stream_if.src drain
);
  localparam int unsigned AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
      $error("sld_fifo: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      wr_ptr_next;
  logic [AW:0]      rd_ptr_reg;
  logic [AW:0]      rd_ptr_next;
  logic [WIDTH-1:0] rd_data_reg;
  logic [WIDTH-1:0] rd_data_next;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  assign full        = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                       (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  assign empty       = (wr_ptr_reg == rd_ptr_reg);
  assign fill.ready  = ~full;
  assign drain.valid = ~empty;
  assign drain.data  = rd_data_reg;
  assign push        = fill.valid & ~full;
  assign pop         = drain.ready & ~empty;

  always_comb begin
    mem_next    = mem_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    if (push) begin
      mem_next[wr_ptr_reg[AW-1:0]] = fill.data;
      wr_ptr_next = wr_ptr_reg + 1'b1;
    end
    if (pop) begin
      rd_ptr_next = rd_ptr_reg + 1'b1;
    end
    // Head word is registered; a push into an empty FIFO shows next cycle
    rd_data_next = mem_next[rd_ptr_next[AW-1:0]];
  end

  always_ff @(posedge clk) begin
    mem_reg     <= mem_next;
    rd_data_reg <= rd_data_next;
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
    end
  end
endmodule // sld_fifo

/* tb/sld_ctrl_model.sv */
// Behavioural controller that drives the link pins of the serial latched driver
`timescale 1ns/100ps
module sld_ctrl_model (
  // Pacing clock
  input  wire logic clk,
  // Link pins
  output logic      shift_clk,
  output logic      serial_in,
  output logic      load,
  output logic      out_disable
);
  // Outputs start disabled because latch contents are unknown at power-up
  initial begin
    shift_clk   = 1'h0;
    serial_in   = 1'h0;
    load        = 1'h0;
    out_disable = 1'h1;
  end
  // Four cycles low, four high: an 800 ns link clock; data leads the rise
  // by three cycles and is released as its inverse when the clock falls
  task automatic send_bit(input logic b);
    @(negedge clk) serial_in = b;
    repeat (3) @(negedge clk);
    shift_clk = 1'h1;
    repeat (4) @(negedge clk);
    shift_clk = 1'h0;
    serial_in = ~b;
  endtask
  task automatic send_byte(input logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      send_bit(d[i]);
    end
  endtask
  // Callers come here at least four cycles after the last rising edge
  task automatic pins(input logic ld, input logic dis);
    @(negedge clk);
    load        = ld;
    out_disable = dis;
  endtask
  // Shift edge, then load after gap cycles; fewer than three breaks the spacing
  task automatic edge_load(input int gap);
    @(negedge clk) serial_in = 1'h1;
    repeat (3) @(negedge clk);
    shift_clk = 1'h1;
    repeat (gap) @(negedge clk);
    load = 1'h1;
    repeat (4) @(negedge clk);
    shift_clk = 1'h0;
    load      = 1'h0;
    serial_in = 1'h0;
  endtask
endmodule // sld_ctrl_model

/* tb/sld_driver_checker.sv */
// Concurrent checks on the serial latched driver ports
`timescale 1ns/100ps
module sld_driver_checker #(parameter int unsigned N_STAGES = 8) (
  // Clock and reset
  input wire logic                clk,
  input wire logic                rst_n,
  // Pins
  input wire logic                shift_clk,
  input wire logic                serial_in,
  input wire logic                load,
  input wire logic                out_disable,
  input wire logic                shift_hold,
  // Status and outputs
  input wire logic                in_ready,
  input wire logic                bit_lost,
  input wire logic                load_gap_err,
  input wire logic                serial_out,
  input wire logic [N_STAGES-1:0] out_on
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence gap_short_s;
    $rose(shift_clk) ##1 $rose(load);
  endsequence
  sequence full_edge_s;
    (!in_ready && shift_hold && $rose(shift_clk)) ##1 shift_hold[*3];
  endsequence
  AST_DIS_OFF: assert property (out_disable[*4] |-> out_on == '0)
    else $error("outputs on while disabled");
  AST_HOLD: assert property ((!load && !out_disable)[*5] |-> $stable(out_on))
    else $error("outputs moved while load low");
  AST_CAUSE: assert property ($changed(out_on) |->
    $past(load, 4) || $past(out_disable, 3) || $past(out_disable, 4))
    else $error("outputs changed without load or disable");
  AST_GAP: assert property (gap_short_s |-> ##[1:6] load_gap_err)
    else $error("early load not flagged");
  AST_GAP_STICKY: assert property (load_gap_err |=> load_gap_err)
    else $error("gap flag cleared");
  AST_LOST_STICKY: assert property (bit_lost |=> bit_lost)
    else $error("lost flag cleared");
  AST_FULL_LOST: assert property (full_edge_s |-> ##[0:3] bit_lost)
    else $error("edge on full buffer not flagged");
  AST_RST_OUT: assert property (disable iff (1'b0) !rst_n |=>
    (out_on == '0 && in_ready && !bit_lost && !load_gap_err && !serial_out))
    else $error("outputs not cleared by reset");
endmodule // sld_driver_checker
bind sld_driver sld_driver_checker #(.N_STAGES(N_STAGES)) u_chk (.clk(clk), .rst_n(rst_n),
  .shift_clk(shift_clk), .serial_in(serial_in), .load(load), .out_disable(out_disable),
  .shift_hold(shift_hold), .in_ready(in_ready), .bit_lost(bit_lost),
  .load_gap_err(load_gap_err), .serial_out(serial_out), .out_on(out_on));

/* tb/tb_top.sv */
// Self-checking bench for the serial latched driver
`timescale 1ns/100ps
module tb_top;
  typedef struct packed {logic [7:0] data; logic dis; logic [7:0] exp;} sld_row_s;
  logic       clk = 1'h0;
  logic       rst_n = 1'h0;
  logic       shift_hold = 1'h0;
  logic       shift_clk, serial_in, load, out_disable;
  logic       in_ready, bit_lost, load_gap_err, serial_out;
  logic [7:0] out_on;
  int         failures = 0;
  int         tests_run = 0;
  sld_row_s   rows [4] = '{'{8'hA5, 1'h0, 8'hA5}, '{8'h3C, 1'h0, 8'h3C},
                           '{8'hC3, 1'h1, 8'h00}, '{8'h0F, 1'h1, 8'h00}};
  sld_ctrl_model ctrl (.clk(clk), .shift_clk(shift_clk), .serial_in(serial_in),
    .load(load), .out_disable(out_disable));
  sld_driver dut (.clk(clk), .rst_n(rst_n),
    .shift_clk(shift_clk), .serial_in(serial_in), .load(load), .out_disable(out_disable),
    .shift_hold(shift_hold), .in_ready(in_ready), .bit_lost(bit_lost),
    .load_gap_err(load_gap_err), .serial_out(serial_out), .out_on(out_on));
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic chk1(input logic a, input logic e);
    tests_run++;
    if (a !== e) begin
      failures++;
      $display("Error %0t: bit %b expected %b", $time, a, e);
    end
  endtask
  task automatic chk8(input logic [7:0] a, input logic [7:0] e);
    tests_run++;
    if (a !== e) begin
      failures++;
      $display("Error %0t: outputs %h expected %h", $time, a, e);
    end
  endtask
  task automatic final_report();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Whole sequence needs about 650 cycles
  initial begin
    repeat (2000) @(posedge clk);
    failures++;
    final_report();
  end
  initial begin
    repeat (8) @(negedge clk);
    chk8(out_on, 8'h00);
    chk1(in_ready, 1'h1);
    rst_n = 1'h1;
    $display("test reset done");
    foreach (rows[i]) begin
      ctrl.pins(1'h0, rows[i].dis);
      ctrl.send_byte(rows[i].data);
      ctrl.pins(1'h1, rows[i].dis);
      repeat (6) @(negedge clk);
      ctrl.pins(1'h0, rows[i].dis);
      repeat (2) @(negedge clk);
      chk8(out_on, rows[i].exp);
      chk1(serial_out, rows[i].data[7]);
      $display("test row %0d done", i);
    end
    ctrl.pins(1'h0, 1'h0);
    repeat (6) @(negedge clk);
    chk8(out_on, 8'h0F);
    ctrl.send_byte(8'hFF);
    repeat (6) @(negedge clk);
    chk8(out_on, 8'h0F);
    $display("test hold done");
    ctrl.pins(1'h1, 1'h1);
    ctrl.send_byte(8'h96);
    ctrl.pins(1'h1, 1'h0);
    repeat (6) @(negedge clk);
    chk8(out_on, 8'h96);
    ctrl.pins(1'h0, 1'h0);
    $display("test transparent done");
    // Exactly the least spacing must pass, one cycle after the edge must not
    ctrl.edge_load(3);
    repeat (4) @(negedge clk);
    chk1(load_gap_err, 1'h0);
    ctrl.edge_load(1);
    repeat (4) @(negedge clk);
    chk1(load_gap_err, 1'h1);
    $display("test load gap done");
    shift_hold = 1'h1;
    repeat (16) ctrl.send_bit(1'h0);
    @(negedge clk);
    chk1(in_ready, 1'h0);
    ctrl.send_bit(1'h1);
    repeat (2) @(negedge clk);
    chk1(bit_lost, 1'h1);
    shift_hold = 1'h0;
    repeat (20) @(negedge clk);
    chk1(in_ready, 1'h1);
    $display("test buffer done");
    rst_n = 1'h0;
    repeat (2) @(negedge clk);
    chk8(out_on, 8'h00);
    chk1(bit_lost, 1'h0);
    chk1(load_gap_err, 1'h0);
    $display("test second reset done");
    final_report();
  end
endmodule // tb_top
